// file: pkg/crs_pkg.sv
package crs_pkg;

  // clock of the sequencer, also the processor bus clock in this system
  localparam int unsigned CLK_PERIOD_NS = 100;

  // least reset width, counted once supply and clock are stable
  localparam int unsigned RESET_MIN_NS = 1000000;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // least set-up of the clock-ratio straps before reset release
  localparam int unsigned RATIO_SETUP_NS = 1000000;
  localparam int unsigned RATIO_SETUP_CYC = (RATIO_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // clock start window that would waive the power-good low width (not exploited)
  localparam int unsigned CLK_FAST_START_NS = 150;

  // bus clock counts
  localparam int unsigned CLK_STABLE_CLKS = 10;
  localparam int unsigned PG_LOW_CLKS = 10;
  localparam int unsigned STRAP_SETUP_CLKS = 4;
  localparam int unsigned STRAP_HOLD_MIN_CLKS = 2;
  localparam int unsigned STRAP_HOLD_MAX_CLKS = 20;
  localparam int unsigned RATIO_DRIVE_MAX_CLKS = 5;
  localparam int unsigned READY_GAP_CLKS = 3;

  // least pulse widths of the sideband pins
  typedef logic [2:0] crs_width_t;
  localparam crs_width_t SB_MIN_W = 3'h2;
  localparam crs_width_t LINT_EDGE_MIN_W = 3'h6;

  // long cycle counter
  typedef logic [15:0] crs_cnt_t;

  // configuration straps sampled by the processor at reset release
  typedef struct packed {
    logic [9:0] addr;
    logic bus_request_zero_n;
    logic flush_n;
    logic init_n;
  } crs_straps_s;

  // clock-ratio straps, carried on sideband pins during reset
  typedef struct packed {
    logic addr_bit20_mask_n;
    logic ignore_fpu_error_n;
    logic [1:0] local_irq_pins;
  } crs_ratio_s;

  // sideband pins towards the processor
  typedef struct packed {
    logic legacy_maskable_irq;
    logic nmi;
    logic addr_bit20_mask_n;
    logic ignore_fpu_error_n;
    logic [1:0] local_irq_pins;
  } crs_sb_s;

  localparam int unsigned SB_BITS = 6;
  localparam crs_sb_s SB_IDLE = 6'h0c;
  localparam int unsigned SB_LINT0 = 0;
  localparam int unsigned SB_LINT1 = 1;
  localparam int unsigned SB_ADDR20_MASK = 3;
  localparam int unsigned SB_FPU_ERR_IGNORE = 2;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_CLK_CNT = 6'h02,
    ST_RESET = 6'h04,
    ST_HOLD = 6'h08,
    ST_RUN = 6'h10,
    ST_PG_DROP = 6'h20
  } crs_state_e;

endpackage

// file: design/crs_min_width.sv
// holds each level of a sideband pin for a least number of clocks
module crs_min_width import crs_pkg::*; #(
  parameter logic IDLE = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire crs_width_t min_i,
  output logic level_o
);

  crs_width_t age_reg; // clocks since the last change, saturating
  logic level_reg; // level on the pin

  // follow the request once the current level has stood long enough
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= IDLE;
      age_reg <= 3'h7;
    end else if (req_i != level_reg && age_reg >= min_i - 3'h1) begin
      level_reg <= req_i;
      age_reg <= 3'h0;
    end else if (age_reg != 3'h7) begin
      age_reg <= age_reg + 3'h1;
    end
  end

  assign level_o = level_reg;

endmodule

// file: design/crs_sequencer.sv
// Function
// - hold processor reset at least 1 ms
// - assert reset freely, release on clock edge
// - three clocks between ready-strobe deassertions
// - sideband levels stand at least 2 clocks
// - edge local interrupt pulses last 6 clocks
// - power-good low at least 10 clocks
// - power-good rises once after 10 stable clocks
// - fast clock start waives power-good width (waiver not used: the clock is always counted first)
// - config straps final 4 clocks before release
// - config straps held 2 to 20 clocks
// - ratio straps set 1 ms before release
// - ratio straps driven within 5 clocks
// - ratio straps held 2 to 20 clocks
// - ratio during reset final or lower
module crs_sequencer import crs_pkg::*; #(
  parameter int unsigned RESET_CYC = RESET_MIN_CYC,
  parameter int unsigned RATIO_CYC = RATIO_SETUP_CYC
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic supply_ok_i,
  input wire logic clk_stable_i,
  input wire logic warm_reset_req_i,
  input wire logic power_cycle_req_i,
  input wire crs_straps_s straps_i,
  input wire crs_ratio_s ratio_i,
  input wire crs_sb_s sb_req_i,
  input wire logic lapic_en_i,
  input wire logic [1:0] lint_edge_i,
  input wire logic ready_req_i,
  output logic power_ok_in_o,
  output logic cpu_reset_n_o,
  output crs_straps_s straps_o,
  output logic straps_oe_o,
  output crs_sb_s sb_pins_o,
  output logic target_ready_n_o,
  output logic ready_pending_o,
  output logic running_o
);

  // longest of the three set-up demands before reset release
  localparam int unsigned REL_AB = (RESET_CYC > RATIO_CYC) ? RESET_CYC : RATIO_CYC;
  localparam int unsigned REL_CYC = (REL_AB > STRAP_SETUP_CLKS) ? REL_AB : STRAP_SETUP_CLKS;

  logic rst_meta; // reset synchroniser, first stage
  logic rst_n; // released reset for the whole design
  logic supply_meta; // supply good synchroniser, first stage
  logic supply_ok; // supply good, synchronised
  logic stable_meta; // clock stable synchroniser, first stage
  logic clk_stable; // clock stable, synchronised

  crs_state_e state_reg; // sequencer state
  crs_state_e state_next;
  crs_cnt_t cnt_reg; // cycles spent in the present state
  crs_cnt_t cnt_next;
  logic capture; // straps are latched on entry to reset

  crs_straps_s straps_reg; // latched config straps
  crs_ratio_s ratio_reg; // latched clock ratio
  logic pg_reg; // power-good pin
  logic rst_out_n_reg; // processor reset pin
  logic oe_reg; // strap pins driven
  crs_straps_s straps_out_reg; // strap pin levels
  crs_sb_s sb_reg; // sideband pin levels
  logic run_reg; // sequence complete

  crs_sb_s sb_gated; // requests after controller-mode gating
  crs_sb_s sb_shaped; // requests after width shaping
  crs_width_t sb_min [SB_BITS]; // least width per pin

  logic pend_reg; // ready strobe waiting
  logic ready_n_reg; // ready strobe pin
  logic [1:0] gap_reg; // clocks since the last strobe deassertion
  logic fire; // strobe goes active this edge

  // external reset released through two flops; assertion stays asynchronous
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // supply and clock status arrive from analog monitors
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      supply_meta <= 1'b0;
      supply_ok <= 1'b0;
      stable_meta <= 1'b0;
      clk_stable <= 1'b0;
    end else begin
      supply_meta <= supply_ok_i;
      supply_ok <= supply_meta;
      stable_meta <= clk_stable_i;
      clk_stable <= stable_meta;
    end
  end

  // next state and counter
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 16'h1;
    capture = 1'b0;
    case (state_reg)
      ST_OFF: begin
        cnt_next = 16'h0;
        if (supply_ok) begin
          state_next = ST_CLK_CNT;
        end
      end
      ST_CLK_CNT: begin
        // the fast-start waiver is not used: the clock is always counted first
        if (!clk_stable) begin
          cnt_next = 16'h0;
        end else if (cnt_reg == 16'(CLK_STABLE_CLKS - 1)) begin
          // power-good rises only after the clock ran cleanly
          state_next = ST_RESET;
          cnt_next = 16'h0;
          capture = 1'b1;
        end
      end
      ST_RESET: begin
        // reset and both strap set-ups are covered by one wait
        if (cnt_reg >= 16'(REL_CYC - 1)) begin
          state_next = ST_HOLD;
          cnt_next = 16'h0;
        end
      end
      ST_HOLD: begin
        // straps stay for the full hold window after release
        if (cnt_reg == 16'(STRAP_HOLD_MAX_CLKS - 1)) begin
          state_next = ST_RUN;
          cnt_next = 16'h0;
        end
      end
      ST_RUN: begin
        cnt_next = 16'h0;
        if (power_cycle_req_i) begin
          state_next = ST_PG_DROP;
        end else if (warm_reset_req_i) begin
          state_next = ST_RESET;
          capture = 1'b1;
        end
      end
      ST_PG_DROP: begin
        // power-good stays low for its least width
        if (cnt_reg == 16'(PG_LOW_CLKS - 1)) begin
          state_next = ST_CLK_CNT;
          cnt_next = 16'h0;
        end
      end
      default: begin
        state_next = ST_OFF;
        cnt_next = 16'h0;
      end
    endcase
    // loss of supply overrides everything
    if (!supply_ok) begin
      state_next = ST_OFF;
      cnt_next = 16'h0;
      capture = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
      cnt_reg <= 16'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // straps are latched once so the ratio cannot move during reset
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      straps_reg <= '0;
      ratio_reg <= '0;
    end else if (capture) begin
      straps_reg <= straps_i;
      ratio_reg <= ratio_i;
    end
  end

  // power-good and reset pins
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      // reset reaches the pin without waiting for a clock
      pg_reg <= 1'b0;
      rst_out_n_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      pg_reg <= (state_next == ST_RESET) || (state_next == ST_HOLD) || (state_next == ST_RUN);
      // release happens only on a clock edge
      rst_out_n_reg <= (state_next == ST_HOLD) || (state_next == ST_RUN);
      run_reg <= state_next == ST_RUN;
    end
  end

  // configuration strap pins
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg <= 1'b0;
      straps_out_reg <= '0;
    end else begin
      oe_reg <= (state_next == ST_RESET) || (state_next == ST_HOLD);
      // final values from the first clock of reset
      straps_out_reg <= capture ? straps_i : straps_reg;
    end
  end

  // pins for the legacy pair open only without the local controller
  always_comb begin
    sb_gated = SB_IDLE;
    if (lapic_en_i) begin
      sb_gated.local_irq_pins = sb_req_i.local_irq_pins;
    end else begin
      sb_gated.legacy_maskable_irq = sb_req_i.legacy_maskable_irq;
      sb_gated.nmi = sb_req_i.nmi;
    end
    sb_gated.addr_bit20_mask_n = sb_req_i.addr_bit20_mask_n;
    sb_gated.ignore_fpu_error_n = sb_req_i.ignore_fpu_error_n;
  end

  // one width shaper per sideband pin
  for (genvar i = 0; i < SB_BITS; i++) begin : g_sb
    if (i == SB_LINT0 || i == SB_LINT1) begin : g_lint
      // edge-configured local pins need the longer pulse
      assign sb_min[i] = (lapic_en_i && lint_edge_i[i]) ? LINT_EDGE_MIN_W : SB_MIN_W;
    end else begin : g_plain
      // plain sideband width
      assign sb_min[i] = SB_MIN_W;
    end
    crs_min_width #(
      .IDLE(SB_IDLE[i])
    ) u_width (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .req_i(sb_gated[i]),
      .min_i(sb_min[i]),
      .level_o(sb_shaped[i])
    );
  end

  // sideband pins carry the ratio outside normal running
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sb_reg <= SB_IDLE;
    end else if (state_next == ST_RUN) begin
      sb_reg <= sb_shaped;
    end else begin
      sb_reg <= SB_IDLE;
      // ratio appears on the same edge that asserts reset
      if (capture) begin
        {sb_reg.addr_bit20_mask_n, sb_reg.ignore_fpu_error_n, sb_reg.local_irq_pins} <= ratio_i;
      end else if (state_next == ST_RESET || state_next == ST_HOLD) begin
        // held through reset and the hold window
        {sb_reg.addr_bit20_mask_n, sb_reg.ignore_fpu_error_n, sb_reg.local_irq_pins} <= ratio_reg;
      end else begin
        {sb_reg.addr_bit20_mask_n, sb_reg.ignore_fpu_error_n, sb_reg.local_irq_pins} <= ratio_i;
      end
    end
  end

  // a waiting strobe fires only after the deassertion gap
  assign fire = pend_reg && ready_n_reg && run_reg && (gap_reg >= 2'(READY_GAP_CLKS - 2));

  // ready strobe, one clock active, spaced by the gap counter
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      ready_n_reg <= 1'b1;
      gap_reg <= 2'h3;
    end else begin
      // a new request in the firing cycle is kept
      pend_reg <= (pend_reg && !fire) || (ready_req_i && run_reg);
      ready_n_reg <= !fire;
      if (!ready_n_reg) begin
        gap_reg <= 2'h0;
      end else if (gap_reg != 2'h3) begin
        gap_reg <= gap_reg + 2'h1;
      end
    end
  end

  assign power_ok_in_o = pg_reg;
  assign cpu_reset_n_o = rst_out_n_reg;
  assign straps_o = straps_out_reg;
  assign straps_oe_o = oe_reg;
  assign sb_pins_o = sb_reg;
  assign target_ready_n_o = ready_n_reg;
  assign ready_pending_o = pend_reg;
  assign running_o = run_reg;

endmodule

// file: tb/crs_cpu_model.sv
// processor seen from the sequencer: syncs sideband pins, latches straps
module crs_cpu_model import crs_pkg::*; (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire crs_straps_s straps_i,
  input wire crs_sb_s sb_i,
  input wire logic lapic_en_i,
  output crs_straps_s cfg_o,
  output crs_ratio_s ratio_o,
  output logic [1:0] irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  crs_sb_s sb_m1; // first sync stage
  crs_sb_s sb_m2; // second sync stage
  logic in_rst; // reset seen, straps not yet taken
  // pins may change at any time, so two flops before use
  always_ff @(posedge clock_i) begin
    sb_m1 <= sb_i;
    sb_m2 <= sb_m1;
  end
  // reset may fall at any moment; straps taken on the edge after release
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_rst <= 1'b1;
    end else begin
      in_rst <= 1'b0;
      if (in_rst) begin
        cfg_o <= straps_i;
        ratio_o <= sb_i[3:0];
      end
    end
  end
  // legacy pin heard only without the local controller, local pin only with it
  always_ff @(posedge clock_i) begin
    irq_o[0] <= !lapic_en_i && sb_m2.legacy_maskable_irq;
    irq_o[1] <= lapic_en_i && sb_m2.local_irq_pins[0];
  end
endmodule

// file: tb/crs_sequencer_asserts.sv
// timing checks on the pins the sequencer drives
module crs_sequencer_asserts import crs_pkg::*; #(
  parameter int unsigned RESET_CYC = 20
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_stable_i,
  input wire crs_ratio_s ratio_i,
  input wire logic lapic_en_i,
  input wire logic [1:0] lint_edge_i,
  input wire logic power_ok_in_o,
  input wire logic cpu_reset_n_o,
  input wire crs_straps_s straps_o,
  input wire logic straps_oe_o,
  input wire crs_sb_s sb_pins_o,
  input wire logic target_ready_n_o,
  input wire logic running_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  crs_cnt_t rst_cnt; // cycles of reset low under good power
  crs_cnt_t stab_cnt; // consecutive cycles of stable clock
  // reset width counter
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i)
      rst_cnt <= '0;
    else if (cpu_reset_n_o)
      rst_cnt <= '0;
    else if (power_ok_in_o)
      rst_cnt <= rst_cnt + 16'h0001;
  end
  // stable clock counter, saturating
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i)
      stab_cnt <= '0;
    else if (!clk_stable_i)
      stab_cnt <= '0;
    else if (stab_cnt != 16'hffff)
      stab_cnt <= stab_cnt + 16'h0001;
  end
  a_rst_width: assert property (
    $rose(cpu_reset_n_o) |-> rst_cnt >= 16'(RESET_CYC)) else $error("reset released too early");
  a_strap_setup: assert property (
    $rose(cpu_reset_n_o) |-> $past(straps_oe_o, 4) && straps_o == $past(straps_o, 4))
    else $error("straps not settled before release");
  a_strap_hold: assert property (
    $rose(cpu_reset_n_o) |-> ##1 (straps_oe_o && $stable(straps_o))[*2] ##[1:18] !straps_oe_o)
    else $error("strap hold window broken");
  a_ratio_drive: assert property (
    $fell(cpu_reset_n_o) |-> ##[0:5] (sb_pins_o[3:0] == ratio_i)) else $error("ratio straps late");
  a_ready_gap: assert property (
    $rose(target_ready_n_o) |=> target_ready_n_o) else $error("ready strobes too close");
  a_pg_low: assert property (
    $fell(power_ok_in_o) |-> !power_ok_in_o[*8] ##1 !power_ok_in_o[*2]) else $error("power-good low too short");
  a_pg_clock: assert property (
    $rose(power_ok_in_o) |-> stab_cnt >= 16'(CLK_STABLE_CLKS)) else $error("power-good before stable clock");
  a_lint_pulse: assert property (
    running_o && lapic_en_i && lint_edge_i[0] && $rose(sb_pins_o[0]) |-> sb_pins_o[0][*6])
    else $error("edge lint pulse too short");
  c_release: cover property ($rose(cpu_reset_n_o));
  c_strobe: cover property ($fell(target_ready_n_o));
  c_pg_drop: cover property ($fell(power_ok_in_o));
endmodule

bind crs_sequencer crs_sequencer_asserts #(.RESET_CYC(RESET_CYC)) u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .clk_stable_i(clk_stable_i), .ratio_i(ratio_i), .lapic_en_i(lapic_en_i), .lint_edge_i(lint_edge_i),
  .power_ok_in_o(power_ok_in_o), .cpu_reset_n_o(cpu_reset_n_o), .straps_o(straps_o), .straps_oe_o(straps_oe_o),
  .sb_pins_o(sb_pins_o), .target_ready_n_o(target_ready_n_o), .running_o(running_o));

// file: tb/crs_sequencer_tb.sv
module crs_sequencer_tb;
  import crs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NCYC = 20; // shortened 1 ms counts
  localparam int LAP[5] = '{0, 1, 1, 1, 0}; // controller enable per case
  localparam int PIN[5] = '{5, 5, 0, 1, 0}; // sideband bit pulsed
  localparam int EXPW[5] = '{2, 0, 6, 2, 0}; // expected width on the pin
  localparam int IRQ[5] = '{1, 0, 1, 0, 0}; // interrupt heard by the processor per case
  localparam int SEL_PG = 0; // watched pin selectors
  localparam int SEL_RST = 1;
  localparam int SEL_RUN = 2;
  localparam int SEL_RDY = 3;
  logic clock_i, arst_n_i, supply_ok_i, clk_stable_i, warm_reset_req_i, power_cycle_req_i;
  logic lapic_en_i, ready_req_i, power_ok_in_o, cpu_reset_n_o, straps_oe_o;
  logic target_ready_n_o, ready_pending_o, running_o;
  logic [1:0] lint_edge_i, irq;
  logic [15:0] w, h;
  crs_straps_s straps_i, straps_o, cfg;
  crs_ratio_s ratio_i, ratio_seen;
  crs_sb_s sb_req_i, sb_pins_o;
  int error_cnt = 0, tests_run = 0, cyc = 0, n;
  crs_sequencer #(.RESET_CYC(NCYC), .RATIO_CYC(NCYC)) crs_sequencer_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .supply_ok_i(supply_ok_i), .clk_stable_i(clk_stable_i), .warm_reset_req_i(warm_reset_req_i),
    .power_cycle_req_i(power_cycle_req_i), .straps_i(straps_i), .ratio_i(ratio_i), .sb_req_i(sb_req_i),
    .lapic_en_i(lapic_en_i), .lint_edge_i(lint_edge_i), .ready_req_i(ready_req_i),
    .power_ok_in_o(power_ok_in_o), .cpu_reset_n_o(cpu_reset_n_o), .straps_o(straps_o),
    .straps_oe_o(straps_oe_o), .sb_pins_o(sb_pins_o), .target_ready_n_o(target_ready_n_o),
    .ready_pending_o(ready_pending_o), .running_o(running_o));
  crs_cpu_model crs_cpu_model_i (.clock_i(clock_i), .reset_n_i(cpu_reset_n_o), .straps_i(straps_o),
    .sb_i(sb_pins_o), .lapic_en_i(lapic_en_i), .cfg_o(cfg), .ratio_o(ratio_seen), .irq_o(irq));
  // compare one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // level of one watched output pin
  function automatic logic pin(input int sel);
    case (sel)
      SEL_PG: return power_ok_in_o;
      SEL_RST: return cpu_reset_n_o;
      SEL_RUN: return running_o;
      default: return target_ready_n_o;
    endcase
  endfunction
  // cycles until a pin shows a level, bounded
  task automatic till(input int sel, input logic v, output int c);
    c = 0;
    while (pin(sel) !== v && c < 300) begin
      @(negedge clock_i);
      c++;
    end
  endtask
  // one-cycle request on a sideband bit, width seen on the pin
  task automatic pulse(input int b, output logic [15:0] wd, output logic [15:0] hit);
    wd = '0;
    hit = '0;
    sb_req_i[b] = 1'b1;
    @(negedge clock_i);
    sb_req_i[b] = 1'b0;
    repeat (12) begin
      @(negedge clock_i);
      wd = wd + 16'(sb_pins_o[b]);
      hit = hit | 16'(|irq);
    end
  endtask
  task automatic results();
    $display("mismatches %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    arst_n_i = 1'b0;
    {supply_ok_i, clk_stable_i, warm_reset_req_i, power_cycle_req_i, ready_req_i} = '0;
    straps_i = 13'h1a5;
    ratio_i = 4'h9;
    sb_req_i = SB_IDLE;
    lapic_en_i = 1'b0;
    lint_edge_i = 2'h1;
    repeat (2) @(negedge clock_i);
    chk("rst_levels", 16'h0000, 16'({power_ok_in_o, cpu_reset_n_o, running_o}));
    chk("rst_ready", 16'h0001, 16'({ready_pending_o, target_ready_n_o}));
    chk("rst_sb", 16'(SB_IDLE), 16'(sb_pins_o));
    arst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    {supply_ok_i, clk_stable_i} = 2'h3;
    till(SEL_PG, 1'b1, n);
    chk("pg_wait", 1, n >= 10 && n < 300);
    till(SEL_RST, 1'b1, n);
    chk("rst_width", 1, n >= NCYC && n < 300);
    till(SEL_RUN, 1'b1, n);
    chk("hold_len", 1, n >= 2 && n <= 20);
    chk("cfg", 16'(straps_i), 16'(cfg));
    chk("ratio", 16'(ratio_i), 16'(ratio_seen));
    // back-to-back strobes
    ready_req_i = 1'b1;
    till(SEL_RDY, 1'b0, n);
    chk("pending", 16'h0001, 16'(ready_pending_o));
    @(negedge clock_i);
    till(SEL_RDY, 1'b0, n);
    ready_req_i = 1'b0;
    chk("ready_gap", 3, 16'(n + 1));
    // the request held through the second strobe gives one more, then nothing waits
    repeat (6) @(negedge clock_i);
    chk("pend_clear", 16'h0000, 16'(ready_pending_o));
    // sideband widths and gating
    for (int i = 0; i < 5; i++) begin
      lapic_en_i = LAP[i][0];
      repeat (8) @(negedge clock_i);
      pulse(PIN[i], w, h);
      chk("sb_width", 16'(EXPW[i]), w);
      chk("irq_seen", 16'(IRQ[i]), h);
    end
    // warm reset with new straps
    straps_i = 13'h0e3c;
    ratio_i = 4'h6;
    warm_reset_req_i = 1'b1;
    @(negedge clock_i);
    warm_reset_req_i = 1'b0;
    chk("warm", 16'h0001, 16'({cpu_reset_n_o, power_ok_in_o}));
    till(SEL_RUN, 1'b1, n);
    chk("warm_cfg", 16'(straps_i), 16'(cfg));
    chk("warm_ratio", 16'(ratio_i), 16'(ratio_seen));
    // power cycle, with a clock dropout during the stable-clock count
    power_cycle_req_i = 1'b1;
    @(negedge clock_i);
    power_cycle_req_i = 1'b0;
    repeat (12) @(negedge clock_i);
    chk("pg_low", 16'h0000, 16'(power_ok_in_o));
    clk_stable_i = 1'b0;
    repeat (3) @(negedge clock_i);
    clk_stable_i = 1'b1;
    till(SEL_PG, 1'b1, n);
    chk("pg_restart", 1, n >= CLK_STABLE_CLKS && n < 300);
    till(SEL_RUN, 1'b1, n);
    chk("restart", 16'h0001, 16'(running_o));
    results();
  end
endmodule
